// *** logic/iod_io_decoder.sv ***
// I/O register space decoder: aliasing, bit access, extended space
//
// Function
// R01 - Bit set and clear reach every register at I/O addresses 0x00 to 0x1F.
// R02 - Bit test on the low range returns whether the selected bit is set.
// R03 - Status flags clear on writing one; writing zero leaves them unchanged.
// R04 - Bit set or clear touches only the addressed bit, never other flags.
// R05 - Bit instructions above I/O address 0x1F are refused.
// R06 - Port instructions use I/O addresses 0x00 to 0x3F, mapped onto registers.
// R07 - Data address equals I/O address plus 0x20; both reach the same register.
// R08 - Extended range 0x60 to 0xFF is reached only by loads and stores.
// R09 - Locations present only on larger variants are reserved on the others.
// R10 - Reserved addresses read zero and ignore writes without side effects.
`timescale 1ns/1ps

module iod_io_decoder
    import iod_pkg::*;
#(
    parameter bit LARGE_VARIANT = 1'b1
) (
    // Clock and reset
    input wire logic clock_i,
    input wire logic resetn_i,
    // Access request from the core
    input wire logic req_i,
    input wire iod_op_t op_i,
    input wire logic [7:0] addr_i,
    input wire logic [2:0] bit_i,
    input wire logic [7:0] wdata_i,
    // Flag events from peripherals
    input wire logic [7:0] timer8_evt_i,
    input wire logic [7:0] timer16_evt_i,
    input wire logic [7:0] pin_change_evt_i,
    input wire logic [7:0] ext_irq_evt_i,
    // Answer to the core
    output logic ack_o,
    output logic fault_o,
    output logic [7:0] rdata_o,
    output logic bit_o,
    // Pending external interrupt
    output logic ext_irq_pending_o
);

    // ------------------------------------------------------------
    // Decode helpers
    // ------------------------------------------------------------

    // Location exists in this map and in this variant
    function automatic logic is_impl(input logic [7:0] a);
        logic hit;
        hit = 1'b0;
        case (a)
            IOD_TIMER8_IRQ_FLAGS, IOD_TIMER16_IRQ_FLAGS, IOD_GP_SCRATCH_1,
            IOD_GP_SCRATCH_2, IOD_PIN_CHANGE_FLAGS, IOD_EXT_IRQ_FLAGS,
            IOD_EXT_IRQ_MASK, IOD_GP_SCRATCH_0, IOD_NVM_DATA_CONTROL,
            IOD_NVM_DATA_BYTE, IOD_NVM_ADDR_LOW, IOD_NVM_ADDR_HIGH,
            IOD_TIMER_GLOBAL_CONTROL, IOD_TIMER8_CONTROL_A, IOD_TIMER8_CONTROL_B,
            IOD_TIMER8_COUNT, IOD_TIMER8_COMPARE_A, IOD_TIMER8_COMPARE_B,
            IOD_PLL_CONTROL_STATUS, IOD_SERIAL_PORT_CONTROL, IOD_SERIAL_PORT_STATUS,
            IOD_SERIAL_PORT_DATA, IOD_COMPARATOR_STATUS, IOD_SLEEP_CONTROL,
            IOD_RESET_CAUSE_STATUS, IOD_CORE_CONTROL, IOD_SELF_PROGRAM_CONTROL,
            IOD_STACK_PTR_LOW, IOD_STACK_PTR_HIGH, IOD_CPU_STATUS_FLAGS,
            IOD_WATCHDOG_CONTROL_STATUS, IOD_CLOCK_PRESCALE, IOD_POWER_REDUCTION,
            IOD_RC_OSC_CALIBRATION, IOD_PIN_CHANGE_CONTROL, IOD_EXT_IRQ_SENSE_CONTROL,
            IOD_PIN_CHANGE_MASK_0, IOD_PIN_CHANGE_MASK_1, IOD_PIN_CHANGE_MASK_2,
            IOD_PIN_CHANGE_MASK_3, IOD_TIMER8_IRQ_MASK,
            IOD_TIMER16_IRQ_MASK: begin
                hit = 1'b1;
            end
            // R09 variant-only locations
            IOD_AMPLIFIER0_CONTROL, IOD_AMPLIFIER1_CONTROL: begin
                hit = LARGE_VARIANT;
            end
            default: begin
                hit = 1'b0;
            end
        endcase
        return hit;
    endfunction

    // Register whose bits clear on a written one
    function automatic logic is_flag(input logic [7:0] a);
        return (a == IOD_TIMER8_IRQ_FLAGS) || (a == IOD_TIMER16_IRQ_FLAGS) ||
               (a == IOD_PIN_CHANGE_FLAGS) || (a == IOD_EXT_IRQ_FLAGS);
    endfunction

    // Bits that exist in a register; the rest read zero
    function automatic logic [7:0] field_mask(input logic [7:0] a);
        logic [7:0] m;
        m = IOD_FULL_MASK;
        if (a == IOD_TIMER8_IRQ_FLAGS) begin
            m = IOD_T8_FLAG_MASK;
        end else if (a == IOD_TIMER16_IRQ_FLAGS) begin
            m = IOD_T16_FLAG_MASK;
        end else if ((a == IOD_PIN_CHANGE_FLAGS) || (a == IOD_EXT_IRQ_FLAGS)) begin
            m = IOD_NIBBLE_MASK;
        end else if (a == IOD_EXT_IRQ_MASK) begin
            m = IOD_NIBBLE_MASK;
        end
        return m;
    endfunction

    // ------------------------------------------------------------
    // Request decode
    // ------------------------------------------------------------
    logic [7:0] daddr;
    logic legal;
    logic bit_op;
    logic [7:0] one_hot;
    logic [7:0] cell_arr [IOD_LO:IOD_HI];

    // Range checks and translation to data space
    always_comb begin
        daddr = addr_i;
        legal = 1'b0;
        bit_op = (op_i == IOD_OP_BSET) || (op_i == IOD_OP_BCLR) ||
                 (op_i == IOD_OP_BTEST);
        if ((op_i == IOD_OP_IN) || (op_i == IOD_OP_OUT)) begin
            // R06 port range, R07 alias, R08 extended range unreachable
            legal = (addr_i <= IOD_IO_LAST);
            daddr = addr_i + IOD_DATA_OFFSET;
        end else if (bit_op) begin
            // R05 bit instructions on the low range only
            legal = (addr_i <= IOD_BIT_LAST);
            daddr = addr_i + IOD_DATA_OFFSET;
        end else if ((op_i == IOD_OP_LOAD) || (op_i == IOD_OP_STORE)) begin
            // R08 loads and stores reach up to the extended end
            legal = (addr_i >= IOD_DATA_OFFSET) && (addr_i <= IOD_EXT_LAST);
        end
    end

    assign one_hot = IOD_ONE_HOT << bit_i;

    // ------------------------------------------------------------
    // Register cells, one per implemented data address
    // ------------------------------------------------------------
    genvar g;
    generate
        for (g = IOD_LO; g <= IOD_HI; g = g + 1) begin : cell_gen
            localparam logic [7:0] A = 8'(g);
            if (is_impl(A)) begin : impl_gen
                logic [7:0] cell_reg;
                logic [7:0] cell_next;
                logic [7:0] evt;
                logic hit;

                assign hit = req_i && legal && (daddr == A);

                // Next value of one register
                always_comb begin
                    if (A == IOD_TIMER8_IRQ_FLAGS) begin
                        evt = timer8_evt_i;
                    end else if (A == IOD_TIMER16_IRQ_FLAGS) begin
                        evt = timer16_evt_i;
                    end else if (A == IOD_PIN_CHANGE_FLAGS) begin
                        evt = pin_change_evt_i;
                    end else if (A == IOD_EXT_IRQ_FLAGS) begin
                        evt = ext_irq_evt_i;
                    end else begin
                        evt = IOD_RESET_VAL;
                    end
                    cell_next = cell_reg | evt;
                    if (hit) begin
                        case (op_i)
                            IOD_OP_OUT, IOD_OP_STORE: begin
                                // R03 write one clears, event set wins
                                if (is_flag(A)) begin
                                    cell_next = (cell_reg & ~wdata_i) | evt;
                                end else begin
                                    cell_next = wdata_i;
                                end
                            end
                            IOD_OP_BSET: begin
                                // R01 R04 only the addressed bit changes
                                if (is_flag(A)) begin
                                    cell_next = (cell_reg & ~one_hot) | evt;
                                end else begin
                                    cell_next = cell_reg | one_hot;
                                end
                            end
                            IOD_OP_BCLR: begin
                                // R04 clearing a flag bit writes zero, no effect
                                if (!is_flag(A)) begin
                                    cell_next = cell_reg & ~one_hot;
                                end
                            end
                            default: begin
                                cell_next = cell_reg | evt;
                            end
                        endcase
                    end
                    cell_next = cell_next & field_mask(A);
                end

                // Storage flop
                always_ff @(posedge clock_i or negedge resetn_i) begin
                    if (!resetn_i) begin
                        cell_reg <= IOD_RESET_VAL;
                    end else begin
                        cell_reg <= cell_next;
                    end
                end

                assign cell_arr[g] = cell_reg;
            end else begin : rsvd_gen
                // R10 reserved location holds nothing and reads zero
                assign cell_arr[g] = IOD_RESET_VAL;
            end
        end
    endgenerate

    // ------------------------------------------------------------
    // Answer path
    // ------------------------------------------------------------
    logic [7:0] rdata_next;
    logic bit_next;

    // Read mux, zero for refused or reserved locations
    always_comb begin
        rdata_next = IOD_RESET_VAL;
        if (req_i && legal) begin
            rdata_next = cell_arr[daddr];
        end
        // R02 selected bit for the skip decision
        bit_next = rdata_next[bit_i];
    end

    // Answer registers, one cycle after the request
    always_ff @(posedge clock_i or negedge resetn_i) begin
        if (!resetn_i) begin
            ack_o <= 1'b0;
            fault_o <= 1'b0;
            rdata_o <= IOD_RESET_VAL;
            bit_o <= 1'b0;
        end else begin
            ack_o <= req_i;
            fault_o <= req_i && !legal;
            rdata_o <= rdata_next;
            bit_o <= req_i && legal && bit_next;
        end
    end

    // Mask steers the pending output
    always_ff @(posedge clock_i or negedge resetn_i) begin
        if (!resetn_i) begin
            ext_irq_pending_o <= 1'b0;
        end else begin
            ext_irq_pending_o <= |(cell_arr[IOD_EXT_IRQ_FLAGS] & cell_arr[IOD_EXT_IRQ_MASK]);
        end
    end

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    localparam logic [7:0] IO_GP0 = IOD_GP_SCRATCH_0 - IOD_DATA_OFFSET;
    localparam logic [7:0] IO_EIF = IOD_EXT_IRQ_FLAGS - IOD_DATA_OFFSET;

    // R06 answer one cycle later
    ack_timing_a: assert property (@(posedge clock_i) disable iff (!resetn_i) // R06
        req_i |=> ack_o ##1 (!ack_o || $past(req_i)))
        else $error("ack not one cycle after request");

    // R05 bit access above low range
    bit_range_a: assert property (@(posedge clock_i) disable iff (!resetn_i) // R05
        (req_i && bit_op && addr_i > IOD_BIT_LAST) |=> (fault_o && !bit_o))
        else $error("bit access above 0x1F not refused");

    // R08 port read (IN) cannot reach extended space
    port_range_a: assert property (@(posedge clock_i) disable iff (!resetn_i) // R08
        (req_i && op_i == IOD_OP_IN && addr_i > IOD_IO_LAST) |=> (fault_o && rdata_o == 8'h00))
        else $error("port access above 0x3F not refused");

    // R07 port write visible through data address
    alias_path_a: assert property (@(posedge clock_i) disable iff (!resetn_i) // R07
        (req_i && op_i == IOD_OP_OUT && addr_i == IO_GP0) |=>
            (cell_arr[IOD_GP_SCRATCH_0] == $past(wdata_i)))
        else $error("port write missed aliased register");

    // R03 write one clears flags, zero keeps them
    flag_clear_a: assert property (@(posedge clock_i) disable iff (!resetn_i) // R03
        (req_i && ext_irq_evt_i == 8'h00 &&
            ((op_i == IOD_OP_STORE && addr_i == IOD_EXT_IRQ_FLAGS) ||
             (op_i == IOD_OP_OUT && addr_i == IO_EIF)))
            |=> (cell_arr[IOD_EXT_IRQ_FLAGS] ==
                 ($past(cell_arr[IOD_EXT_IRQ_FLAGS]) & ~$past(wdata_i))))
        else $error("flag write-one-clear wrong");

    // R01 R04 bit set changes one bit only
    bit_set_a: assert property (@(posedge clock_i) disable iff (!resetn_i) // R04
        (req_i && op_i == IOD_OP_BSET && addr_i == IO_GP0) |=>
            (cell_arr[IOD_GP_SCRATCH_0] == ($past(cell_arr[IOD_GP_SCRATCH_0]) | $past(one_hot))))
        else $error("bit set disturbed other bits");

    // R02 test result matches selected bit
    bit_test_a: assert property (@(posedge clock_i) disable iff (!resetn_i) // R02
        (req_i && op_i == IOD_OP_BTEST && addr_i <= IOD_BIT_LAST) |=>
            (bit_o == $past(cell_arr[addr_i + IOD_DATA_OFFSET][bit_i])))
        else $error("bit test result wrong");

    // R10 reserved location reads zero
    rsvd_read_a: assert property (@(posedge clock_i) disable iff (!resetn_i) // R10
        (req_i && op_i == IOD_OP_LOAD && addr_i == IOD_MONITOR_DATA) |=> (rdata_o == 8'h00))
        else $error("reserved read not zero");

    // R09 variant-only location reserved on small parts
    variant_a: assert property (@(posedge clock_i) disable iff (!resetn_i) // R09
        (!LARGE_VARIANT && req_i && op_i == IOD_OP_LOAD && addr_i == IOD_AMPLIFIER0_CONTROL)
            |=> (rdata_o == 8'h00))
        else $error("variant-only location not reserved");

endmodule

// *** logic/iod_pkg.sv ***
// Constants and types for the I/O register space decoder
package iod_pkg;

    // ------------------------------------------------------------
    // Address space limits
    // ------------------------------------------------------------
    localparam logic [7:0] IOD_BIT_LAST = 8'h1F;     // Last bit-addressable I/O address
    localparam logic [7:0] IOD_IO_LAST = 8'h3F;      // Last port-style I/O address
    localparam logic [7:0] IOD_DATA_OFFSET = 8'h20;  // Data address minus I/O address
    localparam logic [7:0] IOD_EXT_FIRST = 8'h60;    // First extended (load/store only) address
    localparam logic [7:0] IOD_EXT_LAST = 8'hFF;     // Last extended address
    localparam int IOD_LO = 32;                      // Lowest data address held here
    localparam int IOD_HI = 255;                     // Highest data address held here
    localparam logic [7:0] IOD_RESET_VAL = 8'h00;    // Reset value of every register
    localparam logic [7:0] IOD_FULL_MASK = 8'hFF;    // All bits implemented
    localparam logic [7:0] IOD_ONE_HOT = 8'h01;      // Base for single-bit masks

    // ------------------------------------------------------------
    // Register map, data-space addresses
    // ------------------------------------------------------------
    localparam logic [7:0] IOD_TIMER8_IRQ_FLAGS = 8'h35;
    localparam logic [7:0] IOD_TIMER16_IRQ_FLAGS = 8'h36;
    localparam logic [7:0] IOD_GP_SCRATCH_1 = 8'h39;
    localparam logic [7:0] IOD_GP_SCRATCH_2 = 8'h3A;
    localparam logic [7:0] IOD_PIN_CHANGE_FLAGS = 8'h3B;
    localparam logic [7:0] IOD_EXT_IRQ_FLAGS = 8'h3C;
    localparam logic [7:0] IOD_EXT_IRQ_MASK = 8'h3D;
    localparam logic [7:0] IOD_GP_SCRATCH_0 = 8'h3E;
    localparam logic [7:0] IOD_NVM_DATA_CONTROL = 8'h3F;
    localparam logic [7:0] IOD_NVM_DATA_BYTE = 8'h40;
    localparam logic [7:0] IOD_NVM_ADDR_LOW = 8'h41;
    localparam logic [7:0] IOD_NVM_ADDR_HIGH = 8'h42;
    localparam logic [7:0] IOD_TIMER_GLOBAL_CONTROL = 8'h43;
    localparam logic [7:0] IOD_TIMER8_CONTROL_A = 8'h44;
    localparam logic [7:0] IOD_TIMER8_CONTROL_B = 8'h45;
    localparam logic [7:0] IOD_TIMER8_COUNT = 8'h46;
    localparam logic [7:0] IOD_TIMER8_COMPARE_A = 8'h47;
    localparam logic [7:0] IOD_TIMER8_COMPARE_B = 8'h48;
    localparam logic [7:0] IOD_PLL_CONTROL_STATUS = 8'h49;
    localparam logic [7:0] IOD_SERIAL_PORT_CONTROL = 8'h4C;
    localparam logic [7:0] IOD_SERIAL_PORT_STATUS = 8'h4D;
    localparam logic [7:0] IOD_SERIAL_PORT_DATA = 8'h4E;
    localparam logic [7:0] IOD_COMPARATOR_STATUS = 8'h50;
    localparam logic [7:0] IOD_MONITOR_DATA = 8'h51;
    localparam logic [7:0] IOD_MONITOR_STOP_CONTROL = 8'h52;
    localparam logic [7:0] IOD_SLEEP_CONTROL = 8'h53;
    localparam logic [7:0] IOD_RESET_CAUSE_STATUS = 8'h54;
    localparam logic [7:0] IOD_CORE_CONTROL = 8'h55;
    localparam logic [7:0] IOD_SELF_PROGRAM_CONTROL = 8'h57;
    localparam logic [7:0] IOD_STACK_PTR_LOW = 8'h5D;
    localparam logic [7:0] IOD_STACK_PTR_HIGH = 8'h5E;
    localparam logic [7:0] IOD_CPU_STATUS_FLAGS = 8'h5F;
    localparam logic [7:0] IOD_WATCHDOG_CONTROL_STATUS = 8'h60;
    localparam logic [7:0] IOD_CLOCK_PRESCALE = 8'h61;
    localparam logic [7:0] IOD_POWER_REDUCTION = 8'h64;
    localparam logic [7:0] IOD_RC_OSC_CALIBRATION = 8'h66;
    localparam logic [7:0] IOD_PIN_CHANGE_CONTROL = 8'h68;
    localparam logic [7:0] IOD_EXT_IRQ_SENSE_CONTROL = 8'h69;
    localparam logic [7:0] IOD_PIN_CHANGE_MASK_0 = 8'h6A;
    localparam logic [7:0] IOD_PIN_CHANGE_MASK_1 = 8'h6B;
    localparam logic [7:0] IOD_PIN_CHANGE_MASK_2 = 8'h6C;
    localparam logic [7:0] IOD_PIN_CHANGE_MASK_3 = 8'h6D;
    localparam logic [7:0] IOD_TIMER8_IRQ_MASK = 8'h6E;
    localparam logic [7:0] IOD_TIMER16_IRQ_MASK = 8'h6F;
    localparam logic [7:0] IOD_AMPLIFIER0_CONTROL = 8'h75;
    localparam logic [7:0] IOD_AMPLIFIER1_CONTROL = 8'h76;

    // ------------------------------------------------------------
    // Implemented-bit masks of narrow registers
    // ------------------------------------------------------------
    localparam logic [7:0] IOD_T8_FLAG_MASK = 8'h07;
    localparam logic [7:0] IOD_T16_FLAG_MASK = 8'h27;
    localparam logic [7:0] IOD_NIBBLE_MASK = 8'h0F;

    // Access kinds issued by the core
    typedef enum logic [2:0] {
        IOD_OP_IN,
        IOD_OP_OUT,
        IOD_OP_BSET,
        IOD_OP_BCLR,
        IOD_OP_BTEST,
        IOD_OP_LOAD,
        IOD_OP_STORE
    } iod_op_t;

endpackage

// *** sim/iod_core_model.sv ***
// Behavioural core model issuing accesses to the I/O register decoder
`timescale 1ns/1ps

module iod_core_model
    import iod_pkg::*;
(
    // Clock
    input wire logic clock_i,
    // Request to the decoder
    output logic req_o,
    output iod_op_t op_o,
    output logic [7:0] addr_o,
    output logic [2:0] bit_o,
    output logic [7:0] wdata_o,
    // Answer from the decoder
    input wire logic ack_i,
    input wire logic fault_i,
    input wire logic [7:0] rdata_i,
    input wire logic bit_i
);
    // Idle request lines at time zero
    initial begin
        req_o = 1'b0;
        op_o = IOD_OP_IN;
        addr_o = 8'h00;
        bit_o = 3'h0;
        wdata_o = 8'h00;
    end

    // address space per instruction
    // Port and bit ops carry I/O addresses, loads and stores data addresses
    task automatic put(input iod_op_t op, input logic [7:0] a, input logic [2:0] b,
                       input logic [7:0] d);
        req_o = 1'b1;
        op_o = op;
        addr_o = a;
        bit_o = b;
        wdata_o = d;
    endtask

    // Released address, bit and data lines show the inverse of the last value; op_o keeps the last op
    task automatic drop;
        req_o = 1'b0;
        addr_o = ~addr_o;
        bit_o = ~bit_o;
        wdata_o = ~wdata_o;
    endtask

    // One access; answer {ack, fault, bit, data} read in the cycle it stands
    task automatic access(input iod_op_t op, input logic [7:0] a, input logic [2:0] b,
                          input logic [7:0] d, output logic [10:0] ans);
        @(negedge clock_i);
        put(op, a, b, d);
        @(negedge clock_i);
        ans = {ack_i, fault_i, bit_i, rdata_i};
        drop();
    endtask

    // Two requests on consecutive edges
    task automatic access2(input iod_op_t op, input logic [7:0] a1, input logic [7:0] d1,
                           input logic [7:0] a2, input logic [7:0] d2,
                           output logic [1:0] acks);
        @(negedge clock_i);
        put(op, a1, 3'h0, d1);
        @(negedge clock_i);
        acks[1] = ack_i;
        put(op, a2, 3'h0, d2);
        @(negedge clock_i);
        acks[0] = ack_i;
        drop();
    endtask
endmodule

// *** sim/iod_io_decoder_tb.sv ***
// Self-checking testbench for the I/O register space decoder
`timescale 1ns/1ps

module iod_io_decoder_tb
    import iod_pkg::*;
;
    // ------------------------------------------------------------
    // Signals and instances
    // ------------------------------------------------------------
    localparam logic [10:0] FLT = 11'h600;
    logic clock_i = 1'b0;
    logic resetn_i = 1'b0;
    logic req;
    iod_op_t op;
    logic [7:0] addr;
    logic [2:0] bsel;
    logic [7:0] wdata;
    logic [7:0] t8_evt = 8'h00;
    logic [7:0] t16_evt = 8'h00;
    logic [7:0] pc_evt = 8'h00;
    logic [7:0] ei_evt = 8'h00;
    logic ack;
    logic fault;
    logic [7:0] rdata;
    logic bitv;
    logic pend;
    logic [7:0] small_rdata;
    logic [10:0] ans;
    logic [1:0] acks;
    int fails = 0;
    int tests_run = 0;

    // Clock at 40 MHz
    always #12.5 clock_i = ~clock_i;

    iod_io_decoder DUT (.clock_i(clock_i), .resetn_i(resetn_i), .req_i(req), .op_i(op),
        .addr_i(addr), .bit_i(bsel), .wdata_i(wdata), .timer8_evt_i(t8_evt),
        .timer16_evt_i(t16_evt), .pin_change_evt_i(pc_evt), .ext_irq_evt_i(ei_evt),
        .ack_o(ack), .fault_o(fault), .rdata_o(rdata), .bit_o(bitv),
        .ext_irq_pending_o(pend));
    iod_io_decoder #(.LARGE_VARIANT(1'b0)) dut_small (.clock_i(clock_i),
        .resetn_i(resetn_i), .req_i(req), .op_i(op), .addr_i(addr), .bit_i(bsel),
        .wdata_i(wdata), .timer8_evt_i(t8_evt), .timer16_evt_i(t16_evt),
        .pin_change_evt_i(pc_evt), .ext_irq_evt_i(ei_evt), .ack_o(), .fault_o(),
        .rdata_o(small_rdata), .bit_o(), .ext_irq_pending_o());
    iod_core_model core (.clock_i(clock_i), .req_o(req), .op_o(op), .addr_o(addr),
        .bit_o(bsel), .wdata_o(wdata), .ack_i(ack), .fault_i(fault), .rdata_i(rdata),
        .bit_i(bitv));

    // ------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------
    // Expected answer of a legal access returning v
    function automatic logic [10:0] good(input logic [7:0] v, input logic [2:0] b);
        return {2'b10, v[b], v};
    endfunction

    task automatic check(input logic [10:0] got, input logic [10:0] exp, input string what);
        tests_run++;
        if (got !== exp) begin
            fails++;
            $display("[ERR] %0t %s got %h expected %h", $time, what, got, exp);
        end
    endtask

    task automatic xfer(input iod_op_t o, input logic [7:0] a, input logic [2:0] b,
                        input logic [7:0] d, input logic [10:0] exp, input string what);
        core.access(o, a, b, d, ans);
        check(ans, exp, what);
    endtask

    task automatic summarize;
        $display("Comparisons %0d, mismatches %0d", tests_run, fails);
        if (fails == 0 && tests_run > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask

    // ------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------
    task automatic t_reset_vals;
        for (int a = IOD_LO; a <= IOD_HI; a++) begin
            xfer(IOD_OP_LOAD, 8'(a), 3'h0, 8'h00, good(IOD_RESET_VAL, 3'h0), "reset");
        end
    endtask

    task automatic t_alias;
        logic [7:0] io [5] = '{8'h19, 8'h1A, 8'h1E, 8'h20, 8'h3F};
        logic [7:0] v;
        foreach (io[i]) begin
            v = io[i] ^ 8'hA5;
            xfer(IOD_OP_OUT, io[i], 3'h0, v, good(8'h00, 3'h0), "out");
            xfer(IOD_OP_LOAD, io[i] + IOD_DATA_OFFSET, 3'h0, 8'h00, good(v, 3'h0), "ld");
            xfer(IOD_OP_STORE, io[i] + IOD_DATA_OFFSET, 3'h0, ~v, good(v, 3'h0), "st");
            xfer(IOD_OP_IN, io[i], 3'h0, 8'h00, good(~v, 3'h0), "in");
        end
    endtask

    task automatic t_bits;
        logic [7:0] exp = 8'h00;
        xfer(IOD_OP_OUT, 8'h1E, 3'h0, 8'h00, good(8'h44, 3'h0), "clear");
        for (int b = 0; b < 8; b++) begin
            xfer(IOD_OP_BSET, 8'h1E, 3'(b), 8'h00, good(exp, 3'(b)), "bset");
            exp[b] = 1'b1;
            xfer(IOD_OP_BTEST, 8'h1E, 3'(b), 8'h00, good(exp, 3'(b)), "btest");
        end
        xfer(IOD_OP_BCLR, 8'h1E, 3'h3, 8'h00, good(exp, 3'h3), "bclr");
        xfer(IOD_OP_BTEST, 8'h1E, 3'h3, 8'h00, good(8'hF7, 3'h3), "btest low");
        xfer(IOD_OP_BSET, IOD_BIT_LAST, 3'h7, 8'h00, good(8'h00, 3'h7), "bset top");
        xfer(IOD_OP_IN, IOD_BIT_LAST, 3'h0, 8'h00, good(8'h80, 3'h0), "top");
    endtask

    task automatic t_flags;
        @(negedge clock_i);
        t8_evt = 8'hFF;
        t16_evt = 8'hFF;
        pc_evt = 8'h0A;
        ei_evt = 8'h02;
        @(negedge clock_i);
        t8_evt = 8'h00;
        t16_evt = 8'h00;
        pc_evt = 8'h00;
        ei_evt = 8'h00;
        xfer(IOD_OP_IN, 8'h15, 3'h0, 8'h00, good(IOD_T8_FLAG_MASK, 3'h0), "t8");
        xfer(IOD_OP_OUT, 8'h15, 3'h0, 8'h00, good(8'h07, 3'h0), "w0");
        xfer(IOD_OP_OUT, 8'h15, 3'h0, 8'h02, good(8'h07, 3'h0), "w1c");
        xfer(IOD_OP_BSET, 8'h15, 3'h0, 8'h00, good(8'h05, 3'h0), "bset flag");
        xfer(IOD_OP_BCLR, 8'h15, 3'h2, 8'h00, good(8'h04, 3'h2), "bclr flag");
        xfer(IOD_OP_IN, 8'h15, 3'h0, 8'h00, good(8'h04, 3'h0), "flags left");
        xfer(IOD_OP_LOAD, 8'h36, 3'h0, 8'h00, good(IOD_T16_FLAG_MASK, 3'h0), "t16");
        xfer(IOD_OP_STORE, 8'h36, 3'h0, 8'h20, good(8'h27, 3'h0), "st w1c");
        xfer(IOD_OP_IN, 8'h16, 3'h0, 8'h00, good(8'h07, 3'h0), "t16 left");
        xfer(IOD_OP_BTEST, 8'h1B, 3'h3, 8'h00, good(8'h0A, 3'h3), "pc flag");
        check({10'h000, pend}, 11'h000, "pend masked");
        xfer(IOD_OP_OUT, 8'h1D, 3'h0, 8'hFF, good(8'h00, 3'h0), "mask");
        xfer(IOD_OP_IN, 8'h1D, 3'h0, 8'h00, good(IOD_NIBBLE_MASK, 3'h0), "mask rd");
        check({10'h000, pend}, 11'h001, "pend");
        xfer(IOD_OP_OUT, 8'h1C, 3'h0, 8'h02, good(8'h02, 3'h0), "ei w1c");
        @(negedge clock_i);
        check({10'h000, pend}, 11'h000, "pend clr");
    endtask

    task automatic t_refused;
        xfer(IOD_OP_BSET, 8'h20, 3'h0, 8'h00, FLT, "bset high");
        xfer(IOD_OP_BTEST, IOD_IO_LAST, 3'h0, 8'h00, FLT, "btest high");
        xfer(IOD_OP_LOAD, 8'h40, 3'h0, 8'h00, good(8'h7A, 3'h0), "kept");
        xfer(IOD_OP_IN, 8'h40, 3'h0, 8'h00, FLT, "in ext");
        xfer(IOD_OP_STORE, IOD_EXT_FIRST, 3'h0, 8'h9C, good(8'h00, 3'h0), "st ext");
        xfer(IOD_OP_OUT, IOD_EXT_FIRST, 3'h0, 8'h55, FLT, "out ext");
        xfer(IOD_OP_LOAD, IOD_EXT_FIRST, 3'h0, 8'h00, good(8'h9C, 3'h0), "ld ext");
        xfer(IOD_OP_LOAD, 8'h1F, 3'h0, 8'h00, FLT, "ld low");
    endtask

    task automatic t_reserved;
        xfer(IOD_OP_STORE, 8'h61, 3'h0, 8'h12, good(8'h00, 3'h0), "st 61");
        xfer(IOD_OP_STORE, 8'h62, 3'h0, 8'hFF, good(8'h00, 3'h0), "rsvd st");
        xfer(IOD_OP_LOAD, 8'h62, 3'h0, 8'h00, good(8'h00, 3'h0), "rsvd ld");
        xfer(IOD_OP_LOAD, 8'h61, 3'h0, 8'h00, good(8'h12, 3'h0), "neighbour");
        xfer(IOD_OP_OUT, 8'h18, 3'h0, 8'hFF, good(8'h00, 3'h0), "rsvd out");
        xfer(IOD_OP_IN, 8'h18, 3'h0, 8'h00, good(8'h00, 3'h0), "rsvd in");
        xfer(IOD_OP_STORE, 8'h75, 3'h0, 8'h81, good(8'h00, 3'h0), "amp st");
        xfer(IOD_OP_LOAD, 8'h75, 3'h0, 8'h00, good(8'h81, 3'h0), "amp ld");
        check({3'h0, small_rdata}, 11'h000, "small variant");
    endtask

    task automatic t_back;
        core.access2(IOD_OP_STORE, 8'h6A, 8'h11, 8'h6B, 8'h22, acks);
        check({9'h000, acks}, 11'h003, "back to back");
        xfer(IOD_OP_LOAD, 8'h6A, 3'h0, 8'h00, good(8'h11, 3'h0), "first");
        xfer(IOD_OP_LOAD, 8'h6B, 3'h0, 8'h00, good(8'h22, 3'h0), "second");
    endtask

    // Main sequence after 5 cycles of reset
    initial begin
        repeat (5) @(negedge clock_i);
        resetn_i = 1'b1;
        t_reset_vals();
        t_alias();
        t_bits();
        t_flags();
        t_refused();
        t_reserved();
        t_back();
        summarize();
    end

    // Watchdog well beyond the roughly 600 cycles the scenarios need
    initial begin
        #(5000 * 25);
        fails++;
        $display("[ERR] %0t watchdog expired", $time);
        summarize();
    end
endmodule
